// file: src/pcg_top.sv
`timescale 1ns/1ps
`include "pcg_consts.svh"
module pcg_top #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] pad_in,
  output pcg_pkg::pcg_pad_t pad,
  input wire logic scan_active,
  input wire logic scan_tdo,
  input wire logic clk_out_src,
  input wire pcg_pkg::pcg_mon_src_t mon_src,
  output logic monitor_output_pin,
  output logic monitor_output_pin_oe,
  output logic fast_switching_mode
);
  import pcg_pkg::*;

  initial begin
    if (ADDR_W < 9 || ADDR_W > 32) $error("pcg_top: ADDR_W out of range");
  end

  // one-hot select of the four registers; byte address is four times index
  function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    idx = a[ADDR_W-1:2];
    reg_sel[0] = idx == (ADDR_W-2)'(`PCG_IDX_OE);
    reg_sel[1] = idx == (ADDR_W-2)'(`PCG_IDX_VAL);
    reg_sel[2] = idx == (ADDR_W-2)'(`PCG_IDX_LVL);
    reg_sel[3] = idx == (ADDR_W-2)'(`PCG_IDX_CFG);
  endfunction : reg_sel

  logic [7:0] pin_output_enable_r, pin_output_enable_nxt;
  logic [7:0] pin_output_value_r, pin_output_value_nxt;
  logic [7:0] signal_monitor_config_r, signal_monitor_config_nxt;
  logic [7:0] pin_input_level;
  logic [3:0] monitor_signal_select;

  pcg_pin_sync #(
    .W(8)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d(pad_in),
    .level(pin_input_level)
  );

  // write channel
  pcg_wr_state_t wr_r, wr_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic wr_commit;

  always_comb begin
    logic aw_take;
    logic w_take;
    logic [ADDR_W-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [3:0] sel;
    aw_take = s_axi_awvalid && awready_r;
    w_take = s_axi_wvalid && wready_r;
    wa = aw_got_r ? awaddr_r : s_axi_awaddr;
    wd = w_got_r ? wdata_r : s_axi_wdata;
    ws = w_got_r ? wstrb_r : s_axi_wstrb;
    sel = reg_sel(wa);
    wr_nxt = wr_r;
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = aw_take ? s_axi_awaddr : awaddr_r;
    wdata_nxt = w_take ? s_axi_wdata : wdata_r;
    wstrb_nxt = w_take ? s_axi_wstrb : wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    wr_commit = 1'b0;
    pin_output_enable_nxt = pin_output_enable_r;
    pin_output_value_nxt = pin_output_value_r;
    signal_monitor_config_nxt = signal_monitor_config_r;
    unique case (wr_r)
      PCG_WR_IDLE: begin
        // address and data may arrive in either order
        if ((aw_got_r || aw_take) && (w_got_r || w_take)) begin
          wr_commit = 1'b1;
          wr_nxt = PCG_WR_RESP;
          awready_nxt = 1'b0;
          wready_nxt = 1'b0;
          aw_got_nxt = 1'b0;
          w_got_nxt = 1'b0;
          bvalid_nxt = 1'b1;
          bresp_nxt = (|sel) ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
          // only byte lane 0 carries register bits
          if (ws[0]) begin
            if (sel[0]) pin_output_enable_nxt = wd[7:0];
            if (sel[1]) pin_output_value_nxt = wd[7:0];
            if (sel[3]) begin
              signal_monitor_config_nxt = wd[7:0] & `PCG_CFG_WMASK;
            end
          end
        end else begin
          aw_got_nxt = aw_got_r || aw_take;
          w_got_nxt = w_got_r || w_take;
          awready_nxt = !(aw_got_r || aw_take);
          wready_nxt = !(w_got_r || w_take);
        end
      end
      PCG_WR_RESP: begin
        if (s_axi_bready) begin
          wr_nxt = PCG_WR_IDLE;
          bvalid_nxt = 1'b0;
          awready_nxt = 1'b1;
          wready_nxt = 1'b1;
        end
      end
      default: begin
        wr_nxt = PCG_WR_IDLE;
        bvalid_nxt = 1'b0;
        awready_nxt = 1'b1;
        wready_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_r <= PCG_WR_IDLE;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `PCG_RESP_OKAY;
      pin_output_enable_r <= `PCG_OE_RST;
      pin_output_value_r <= `PCG_VAL_RST;
      signal_monitor_config_r <= `PCG_CFG_RST;
    end else if (ce) begin
      wr_r <= wr_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      pin_output_enable_r <= pin_output_enable_nxt;
      pin_output_value_r <= pin_output_value_nxt;
      signal_monitor_config_r <= signal_monitor_config_nxt;
    end
  end

  // read channel
  pcg_rd_state_t rd_r, rd_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  always_comb begin
    logic [3:0] sel;
    logic [7:0] val;
    sel = reg_sel(s_axi_araddr);
    val = 8'h00;
    if (sel[0]) val = pin_output_enable_r;
    if (sel[1]) val = pin_output_value_r;
    if (sel[2]) val = pin_input_level;
    if (sel[3]) val = signal_monitor_config_r;
    rd_nxt = rd_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    unique case (rd_r)
      PCG_RD_IDLE: begin
        if (s_axi_arvalid && arready_r) begin
          rd_nxt = PCG_RD_DATA;
          arready_nxt = 1'b0;
          rvalid_nxt = 1'b1;
          rdata_nxt = {24'h0, val};
          rresp_nxt = (|sel) ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
        end
      end
      PCG_RD_DATA: begin
        if (s_axi_rready) begin
          rd_nxt = PCG_RD_IDLE;
          arready_nxt = 1'b1;
          rvalid_nxt = 1'b0;
        end
      end
      default: begin
        rd_nxt = PCG_RD_IDLE;
        arready_nxt = 1'b1;
        rvalid_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_r <= PCG_RD_IDLE;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `PCG_RESP_OKAY;
    end else if (ce) begin
      rd_r <= rd_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // pads, monitor pin and speed; all registered so pins never glitch
  pcg_pad_t pad_r, pad_nxt;
  logic mon_r, mon_nxt, mon_oe_r, mon_oe_nxt, fast_r, fast_nxt;

  assign monitor_signal_select = signal_monitor_config_r[3:0];

  always_comb begin
    logic [7:0] oe_eff;
    oe_eff = pin_output_enable_r;
    if (scan_active) oe_eff = oe_eff & ~`PCG_SCAN_MASK;
    pad_nxt.oe = oe_eff;
    pad_nxt.out = pin_output_value_r & oe_eff;
    // clock output pin keeps its clock unless taken over by software
    if (!oe_eff[`PCG_PIN_CLOCK_OUTPUT_PIN]) begin
      pad_nxt.oe[`PCG_PIN_CLOCK_OUTPUT_PIN] = 1'b1;
      pad_nxt.out[`PCG_PIN_CLOCK_OUTPUT_PIN] = clk_out_src;
    end
    // scan owns the scan pins; TDO is its only output among them
    if (scan_active) begin
      pad_nxt.oe[`PCG_PIN_TDO] = 1'b1;
      pad_nxt.out[`PCG_PIN_TDO] = scan_tdo;
    end
    fast_nxt = signal_monitor_config_r[`PCG_CFG_FAST];
    mon_oe_nxt = 1'b1;
    mon_nxt = 1'b0;
    // unlisted codes leave the pin undriven, the safest choice
    case (monitor_signal_select)
      `PCG_MON_LOW: mon_nxt = 1'b0;
      `PCG_MON_HIGH: mon_nxt = 1'b1;
      `PCG_MON_TXENV: mon_nxt = mon_src.tx_env;
      `PCG_MON_TXACT: mon_nxt = mon_src.tx_act;
      `PCG_MON_SER: mon_nxt = mon_src.serial;
      `PCG_MON_RXENV: mon_nxt = mon_src.rx_env;
      `PCG_MON_RXACT: mon_nxt = mon_src.rx_act;
      `PCG_MON_RXBIT: mon_nxt = mon_src.rx_bit;
      default: mon_oe_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pad_r <= '0;
      mon_r <= 1'b0;
      mon_oe_r <= 1'b0;
      fast_r <= 1'b0;
    end else if (ce) begin
      pad_r <= pad_nxt;
      mon_r <= mon_nxt;
      mon_oe_r <= mon_oe_nxt;
      fast_r <= fast_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign pad = pad_r;
  assign monitor_output_pin = mon_r;
  assign monitor_output_pin_oe = mon_oe_r;
  assign fast_switching_mode = fast_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_level_read;
    ce && s_axi_arvalid && arready_r && reg_sel(s_axi_araddr) == 4'h4;
  endsequence

  sequence s_cfg_write;
    ce && wr_commit && reg_sel(aw_got_r ? awaddr_r : s_axi_awaddr) == 4'h8
      && (w_got_r ? wstrb_r[0] : s_axi_wstrb[0]);
  endsequence

  property p_signal_input_pin_out;
    ce && pin_output_enable_r[7] |=>
      pad.oe[7] && pad.out[7] == $past(pin_output_value_r[7]);
  endproperty
  a_signal_input_pin_out: assert property (p_signal_input_pin_out)
    else $error("signal input pin not driven from value bit");

  property p_clock_output_pin;
    ce && !pin_output_enable_r[6] |=> pad.oe[6] && pad.out[6] == $past(clk_out_src);
  endproperty
  a_clock_output_pin: assert property (p_clock_output_pin)
    else $error("clock output pin lost its clock function");

  property p_ifsel;
    ce |=> pad.oe[5:4] == $past(pin_output_enable_r[5:4]);
  endproperty
  a_ifsel: assert property (p_ifsel)
    else $error("interface-select enables not applied");

  property p_scan_pins;
    ce && !scan_active |=> pad.oe[3:0] == $past(pin_output_enable_r[3:0]);
  endproperty
  a_scan_pins: assert property (p_scan_pins)
    else $error("scan pin enables not applied");

  property p_scan_ignore;
    ce && scan_active |=> pad.oe[3:0] == 4'h1 && pad.out[0] == $past(scan_tdo);
  endproperty
  a_scan_ignore: assert property (p_scan_ignore)
    else $error("scan pins driven from software while scan active");

  property p_tdo_value;
    ce && !scan_active && pin_output_enable_r[0] |=>
      pad.out[0] == $past(pin_output_value_r[0]);
  endproperty
  a_tdo_value: assert property (p_tdo_value)
    else $error("tdo pin not driven from value bit 0");

  property p_level_read;
    s_level_read |=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(pin_input_level)};
  endproperty
  a_level_read: assert property (p_level_read)
    else $error("input level read returned wrong data");

  property p_cfg_write;
    s_cfg_write |=> signal_monitor_config_r ==
      ($past(w_got_r ? wdata_r[7:0] : s_axi_wdata[7:0]) & `PCG_CFG_WMASK);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config write not stored");

  property p_fast;
    ce |=> fast_switching_mode == $past(signal_monitor_config_r[7]);
  endproperty
  a_fast: assert property (p_fast)
    else $error("fast mode does not follow speed bit");

  property p_mon_fixed;
    ce && monitor_signal_select inside {4'h2, 4'h3} |=>
      monitor_output_pin_oe && monitor_output_pin == $past(monitor_signal_select[0]);
  endproperty
  a_mon_fixed: assert property (p_mon_fixed)
    else $error("monitor pin fixed level wrong");

  property p_mon_hiz;
    ce && monitor_signal_select < 4'h2 |=> !monitor_output_pin_oe;
  endproperty
  a_mon_hiz: assert property (p_mon_hiz)
    else $error("monitor pin driven while select is hi-z");

  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped before taken");

endmodule : pcg_top

// file: src/pcg_consts.svh
// Overview of operation
// - enable bit 7 set: signal input pin becomes a driven output.
// - enable bit 6 set: clock output function off, pin is general output.
// - enable bits 5 and 4 make interface-select pins 1 and 0 outputs.
// - enable bits 3..0 make scan pins TCK, TMS, TDI, TDO outputs.
// - with boundary scan active, enable bits 3..0 are ignored.
// - each output-value bit is the level driven on its pin; bit 7 signal input.
// - output-value bits follow the enable order; bit 0 drives TDO.
// - input-level register returns each pin's present input level.
// - config register at index 47h: bit 7 speed, low bits monitor select.
// - speed bit set puts the pads in fast switching mode.
// - monitor select picks hi-z, 0, 1 or an internal signal for monitor pin.
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH

`define PCG_IDX_OE 7'h44
`define PCG_IDX_VAL 7'h45
`define PCG_IDX_LVL 7'h46
`define PCG_IDX_CFG 7'h47

`define PCG_PIN_CLOCK_OUTPUT_PIN 6
`define PCG_PIN_TDO 0
`define PCG_SCAN_MASK 8'h0F

`define PCG_OE_RST 8'h00
`define PCG_VAL_RST 8'h00
`define PCG_CFG_RST 8'h00
`define PCG_CFG_WMASK 8'h8F
`define PCG_CFG_FAST 7

`define PCG_MON_LOW 4'h2
`define PCG_MON_HIGH 4'h3
`define PCG_MON_TXENV 4'h4
`define PCG_MON_TXACT 4'h5
`define PCG_MON_SER 4'h6
`define PCG_MON_RXENV 4'h7
`define PCG_MON_RXACT 4'h8
`define PCG_MON_RXBIT 4'h9

`define PCG_RESP_OKAY 2'h0
`define PCG_RESP_SLVERR 2'h2

`endif

// file: src/pcg_pkg.sv
package pcg_pkg;

  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] out;
  } pcg_pad_t;

  typedef struct packed {
    logic tx_env;
    logic tx_act;
    logic serial;
    logic rx_env;
    logic rx_act;
    logic rx_bit;
  } pcg_mon_src_t;

  typedef enum logic [1:0] {
    PCG_WR_IDLE = 2'b01,
    PCG_WR_RESP = 2'b10
  } pcg_wr_state_t;

  typedef enum logic [1:0] {
    PCG_RD_IDLE = 2'b01,
    PCG_RD_DATA = 2'b10
  } pcg_rd_state_t;

endpackage : pcg_pkg

// file: src/pcg_pin_sync.sv
`timescale 1ns/1ps
module pcg_pin_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] level
);
  import pcg_pkg::*;

  logic [W-1:0] s1_r, s2_r, s3_r, level_r;
  logic [W-1:0] level_nxt;

  initial begin
    if (W < 1) $error("pcg_pin_sync: W must be at least 1");
  end

  // a bit changes only once the second and third stages agree
  always_comb begin
    level_nxt = level_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) level_nxt[i] = s3_r[i];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      level_r <= '0;
    end else if (ce) begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;

  property p_level_follows;
    @(posedge clk) disable iff (rst)
      ce && (s2_r == s3_r) |=> level_r == $past(s3_r);
  endproperty
  a_level_follows: assert property (p_level_follows)
    else $error("input level did not follow agreeing stages");

endmodule : pcg_pin_sync

// file: tb/pcg_board.sv
`timescale 1ns/1ps
// board side of the repurposed pins: a driven pin shows the device level,
// an undriven one falls back to whatever the board holds it at
module pcg_board (
  input wire pcg_pkg::pcg_pad_t pad,
  input wire logic [7:0] ext_level,
  output logic [7:0] pad_in
);
  import pcg_pkg::*;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_in[i] = pad.oe[i] ? pad.out[i] : ext_level[i];
    end
  end
endmodule : pcg_board

// file: tb/tb.sv
`timescale 1ns/1ps
`include "pcg_consts.svh"
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin \
  fail_count++; $display("CHECK FAILED %0t %s", $time, m); end end
module tb;
  import pcg_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  pcg_pad_t pad, p;
  pcg_mon_src_t mon_src = '0;
  logic [7:0] pad_in, ext = 8'h00, lvl;
  logic scan_active = 1'b0, scan_tdo = 1'b0, clk_out_src = 1'b0;
  logic mon_pin, mon_oe, fast;
  logic [3:0] sel;
  logic [1:0] mx;
  int fail_count = 0, checked = 0, cycles = 0;
  int seed = 32'hfb885d5a;
  int regs[4] = '{0, 0, 0, 0};

  pcg_top #(.ADDR_W(12)) DUT (.clk(clk), .rst(rst), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pad_in(pad_in),
    .pad(pad), .scan_active(scan_active), .scan_tdo(scan_tdo),
    .clk_out_src(clk_out_src), .mon_src(mon_src),
    .monitor_output_pin(mon_pin), .monitor_output_pin_oe(mon_oe),
    .fast_switching_mode(fast));
  pcg_board board (.pad(pad), .ext_level(ext), .pad_in(pad_in));

  always #4 clk = ~clk;

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end

  function automatic logic mapped(input logic [11:0] a);
    return a[11:2] >= 10'h44 && a[11:2] <= 10'h47;
  endfunction : mapped

  // upper data bits are random on purpose: they must not leak into a register
  task automatic axw(input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    int k;
    k = int'(a[11:2]) - 'h44;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'($random(seed)), d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    `CHK(bresp, mapped(a) ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR, "wr resp")
    bready <= 1'b0;
    if (mapped(a) && s[0] && k != 2) regs[k] = (k == 3) ? d & 8'h8F : d;
  endtask : axw

  task automatic axr(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    `CHK(rdata, {24'h0, mapped(a) ? e : 8'h00}, "rd data")
    `CHK(rresp, mapped(a) ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR, "rd resp")
    rready <= 1'b0;
  endtask : axr

  task automatic expect_pins();
    p.oe = regs[0][7:0];
    p.out = regs[0][7:0] & regs[1][7:0];
    if (!regs[0][6]) begin
      p.oe[6] = 1'b1;
      p.out[6] = clk_out_src;
    end
    if (scan_active) begin
      p.oe[3:0] = 4'h1;
      p.out[3:0] = {3'b000, scan_tdo};
    end
    lvl = (p.oe & p.out) | (~p.oe & ext);
    sel = regs[3][3:0];
    mx = (sel == 4'h2 || sel == 4'h3) ? {1'b1, sel[0]} :
         (sel >= 4'h4 && sel <= 4'h9) ? {1'b1, mon_src[4'h9 - sel]} : 2'b00;
  endtask : expect_pins

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 4; k++) axr(12'h110 + 12'(4 * k), 8'h00);
    // one monitor code per pass so every select value is seen
    for (int i = 0; i < 16; i++) begin
      scan_active <= 1'($random(seed));
      scan_tdo <= 1'($random(seed));
      clk_out_src <= 1'($random(seed));
      mon_src <= 6'($random(seed));
      ext <= 8'($random(seed));
      axw(12'h110, 8'($random(seed)), 4'hF);
      axw(12'h114, 8'($random(seed)), 4'hF);
      axw(12'h11C, {4'($random(seed)), 4'(i)}, 4'hF);
      repeat (8) @(posedge clk);
      expect_pins();
      `CHK(pad.oe[7:4], p.oe[7:4], "pin enables high")
      `CHK(pad.out[6], p.out[6], "clock pin level")
      `CHK(pad.oe[5:4], p.oe[5:4], "select pins")
      `CHK(pad.oe[3:0], p.oe[3:0], "scan pin enables")
      `CHK(pad.out[3:0], p.out[3:0], "scan pin levels")
      `CHK(pad.out[7], p.out[7], "signal pin level")
      `CHK(pad.out[0], p.out[0], "tdo pin level")
      `CHK(pad, p, "undriven pins")
      `CHK(fast, regs[3][7], "speed")
      `CHK(mon_oe, mx[1], "monitor enable")
      if (mx[1]) `CHK(mon_pin, mx[0], "monitor level")
      axr(12'h110, regs[0][7:0]);
      axr(12'h114, regs[1][7:0]);
      axr(12'h11C, regs[3][7:0]);
      axr(12'h118, lvl);
    end
    // clock enable low must freeze the pads even when scan mode flips
    ce <= 1'b0;
    scan_active <= ~scan_active;
    repeat (4) @(posedge clk);
    `CHK(pad, p, "pads frozen while ce low")
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    expect_pins();
    `CHK(pad, p, "pads after ce returns")
    axw(12'h118, 8'hA5, 4'hF);
    axr(12'h118, lvl);
    axw(12'h110, 8'h3C, 4'hE);
    axr(12'h110, regs[0][7:0]);
    axw(12'h200, 8'hFF, 4'hF);
    axr(12'h10C, 8'h00);
    axr(12'h120, 8'h00);
    final_report();
  end
endmodule : tb
